// ==== pcm_pack_pkg.sv ====
package pcm_pack_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int unsigned DATA_W = 64;
	localparam int unsigned BITS_W = 7;
	localparam int unsigned WORD_W = 16;
	localparam int unsigned ACC_W  = 80;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_FRAMES = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_CSW    = 8'h0C;

	localparam int         CTRL_EN      = 0;
	localparam int         CTRL_PACKED  = 1;
	localparam int         CTRL_ALIGN32 = 2;
	localparam int         CTRL_FILL1   = 3;
	localparam logic [3:0] CTRL_RST     = 4'h0;
	localparam logic [7:0] FRAMES_RST   = 8'h01;

	// ----------------------------------------------------------------
	// channel-specific word fields
	// ----------------------------------------------------------------
	localparam int CSW_IPH      = 30;
	localparam int CSW_MINOR    = 28;
	localparam int CSW_LOCK_LSB = 24;
	localparam int CSW_ALIGN    = 21;
	localparam int CSW_PACKED   = 19;
	localparam int CSW_UNPACKED = 18;

	// ----------------------------------------------------------------
	// sequencing
	// ----------------------------------------------------------------
	localparam logic [2:0] IPH_LAST  = 3'h5;
	localparam logic [6:0] SLOT_BITS = 7'h10;
	localparam logic [6:0] LONG_BITS = 7'h20;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CSW_LO,
		ST_CSW_HI,
		ST_IPH,
		ST_DATA,
		ST_END,
		ST_FIN
	} state_t;

endpackage

// ==== stream16_if.sv ====
`timescale 1ns/1ps
interface stream16_if;
	logic        valid;
	logic        ready;
	logic        last;
	logic [15:0] data;

	modport src (output valid, output data, output last, input ready);
	modport snk (input valid, input data, input last, output ready);
endinterface

// ==== bit_packer.sv ====
`timescale 1ns/1ps
module bit_packer
	import pcm_pack_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              push,
	input  wire logic [DATA_W-1:0] push_data,
	input  wire logic [BITS_W-1:0] push_bits,
	input  wire logic              pop,
	input  wire logic              flush,
	input  wire logic              fill,
	output logic      [WORD_W-1:0] word,
	output logic      [7:0]        cnt
);
	logic [ACC_W-1:0] acc_q;
	logic [7:0]       cnt_q;

	// bits enter at the current fill level, so the earliest bit lands lowest
	wire logic [ACC_W-1:0]  push_sh = {16'h0000, push_data} << cnt_q;
	wire logic [WORD_W-1:0] gap     = (cnt_q >= 8'h10) ? 16'h0000 : ~16'((17'h00001 << cnt_q) - 17'h00001);

	assign word = acc_q[15:0] | (fill ? gap : 16'h0000);
	assign cnt  = cnt_q;

	// push only arrives with fewer than 16 bits held, so nothing overflows
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_q <= '0;
			cnt_q <= 8'h00;
		end else if (pop) begin
			acc_q <= acc_q >> WORD_W;
			cnt_q <= cnt_q - 8'h10;
		end else if (flush) begin
			acc_q <= '0;
			cnt_q <= 8'h00;
		end else if (push) begin
			acc_q <= acc_q | push_sh;
			cnt_q <= cnt_q + {1'b0, push_bits};
		end
	end
endmodule

// ==== word_skid_buffer.sv ====
`timescale 1ns/1ps
module word_skid_buffer
	import pcm_pack_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_n,
	stream16_if.snk                up,
	output logic                   out_valid,
	output logic      [WORD_W-1:0] out_data,
	output logic                   out_last,
	input  wire logic              out_ready
);
	logic              skid_v_q;
	logic [WORD_W-1:0] skid_d_q;
	logic              skid_l_q;

	// ready is a flop: the second entry absorbs the word taken while stalled
	assign up.ready = ~skid_v_q;
	wire logic take = up.valid & ~skid_v_q;
	wire logic free = out_ready | ~out_valid;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_valid <= 1'b0;
			out_data  <= 16'h0000;
			out_last  <= 1'b0;
			skid_v_q  <= 1'b0;
			skid_d_q  <= 16'h0000;
			skid_l_q  <= 1'b0;
		end else if (take && !free) begin
			skid_v_q <= 1'b1;
			skid_d_q <= up.data;
			skid_l_q <= up.last;
		end else if (take) begin
			out_valid <= 1'b1;
			out_data  <= up.data;
			out_last  <= up.last;
		end else if (free) begin
			out_valid <= skid_v_q;
			out_data  <= skid_d_q;
			out_last  <= skid_l_q;
			skid_v_q  <= 1'b0;
		end
	end
endmodule

// ==== pcm_minor_frame_packer.sv ====
// The placing of the registers and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
// Summary of operation
// - 16-bit alignment: sync over 16 bits split into (bits+15)/16 words.
// - 32-bit alignment: sync over 32 bits split into (bits+31)/32 long words.
// - uneven split: first piece smallest, later pieces equal, each bits/pieces rounded up.
// - unpacked 24-bit sync becomes two padded 12-bit words, upper half first.
// - unpacked words narrower than 16 bits are right-aligned, pad above.
// - packed mode concatenates words with no per-word padding.
// - packed mode appends N minus (L mod N) filler bits per frame when L mod N is nonzero.
// - packed data starts with the first bit of a minor frame.
// - each frame preceded by time stamp (four words, low first) and data header.
// - all filler and pad bits are uniformly zeros or uniformly ones.
// - unpacked 32-bit alignment adds a filler word for odd word counts.
// - channel word alignment bit: 0 for 16-bit, 1 for 32-bit.
module pcm_minor_frame_packer
	import pcm_pack_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [7:0]        wb_adr_i,
	input  wire logic [31:0]       wb_dat_i,
	input  wire logic [3:0]        wb_sel_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	input  wire logic              in_valid,
	output logic                   in_ready,
	input  wire logic [DATA_W-1:0] in_data,
	input  wire logic [BITS_W-1:0] in_bits,
	input  wire logic              in_sync,
	input  wire logic              in_last,
	input  wire logic [63:0]       time_stamp,
	input  wire logic [31:0]       data_header,
	input  wire logic [3:0]        lock_status,
	output logic                   out_valid,
	output logic      [WORD_W-1:0] out_data,
	output logic                   out_last,
	input  wire logic              out_ready
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [DATA_W-1:0] low_mask(input logic [6:0] w);
		low_mask = (w >= 7'h40) ? 64'hFFFF_FFFF_FFFF_FFFF : ((64'h1 << w) - 64'h1);
	endfunction

	function automatic logic [6:0] share(input logic [6:0] bits, input logic [2:0] k);
		case (k)
			3'h1:    share = bits;
			3'h2:    share = 7'((bits + 7'h01) >> 1);
			3'h3:    share = 7'((8'(bits) + 8'h02) / 8'h03);
			default: share = 7'((bits + 7'h03) >> 2);
		endcase
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	state_t      st_q, st_d;
	logic [3:0]  ctrl_q;
	logic [7:0]  frames_q, fcnt_q, pkt_cnt_q;
	logic        cfg_packed_q, cfg_a32_q, cfg_fill_q;
	logic [31:0] csw_q;
	logic [63:0] ts_q;
	logic [31:0] dh_q;
	logic [2:0]  iph_q;
	logic        par_q, last_seen_q, in_ready_q;
	logic        stage_v_q;
	logic [15:0] stage_q;
	logic        h_v_q, h_first_q, h_slot32_q, h_half_q;
	logic [63:0] h_q;
	logic [6:0]  h_cnt_q, h_f_q, h_s_q;
	logic [15:0] pk_word;
	logic [7:0]  pk_cnt;

	stream16_if bus ();

	assign in_ready = in_ready_q;

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	wire logic wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire logic wb_wr  = wb_req & wb_we_i & wb_sel_i[0];
	wire logic busy   = (st_q != ST_IDLE);
	wire logic [31:0] rd_mux =
		(wb_adr_i == ADDR_CTRL)   ? {28'h0, ctrl_q} :
		(wb_adr_i == ADDR_FRAMES) ? {24'h0, frames_q} :
		(wb_adr_i == ADDR_STATUS) ? {15'h0, busy, pkt_cnt_q, fcnt_q} :
		(wb_adr_i == ADDR_CSW)    ? csw_q : 32'h0;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
			ctrl_q   <= CTRL_RST;
			frames_q <= FRAMES_RST;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= wb_req ? rd_mux : 32'h0;
			if (wb_wr && wb_adr_i == ADDR_CTRL)
				ctrl_q <= wb_dat_i[3:0];
			if (wb_wr && wb_adr_i == ADDR_FRAMES)
				frames_q <= wb_dat_i[7:0];
		end
	end

	// ----------------------------------------------------------------
	// channel word
	// ----------------------------------------------------------------
	wire logic pkt_start = (st_q == ST_IDLE) & ctrl_q[CTRL_EN];
	logic [31:0] csw_w;
	always_comb begin
		csw_w = 32'h0;
		csw_w[CSW_IPH] = 1'b1;
		csw_w[CSW_MINOR] = 1'b1;
		csw_w[CSW_LOCK_LSB +: 4] = lock_status;
		csw_w[CSW_ALIGN] = ctrl_q[CTRL_ALIGN32];
		csw_w[CSW_PACKED] = ctrl_q[CTRL_PACKED];
		csw_w[CSW_UNPACKED] = ~ctrl_q[CTRL_PACKED];
	end

	// ----------------------------------------------------------------
	// item split on accept
	// ----------------------------------------------------------------
	wire logic       accept    = in_valid & in_ready_q;
	wire logic       ld_big    = in_bits > SLOT_BITS;
	// long sync in 32-bit alignment uses 32-bit slots
	wire logic       ld_slot32 = cfg_a32_q & (in_bits > LONG_BITS);
	wire logic [2:0] ld_k      = !ld_big ? 3'h1 :
		ld_slot32 ? 3'((in_bits + 7'h1F) >> 5) : 3'((in_bits + 7'h0F) >> 4);
	wire logic [6:0] ld_s      = share(in_bits, ld_k);
	wire logic [6:0] ld_km1    = {4'h0, ld_k - 3'h1};
	// first piece takes what the larger later pieces leave
	wire logic [6:0] ld_f      = in_bits - 7'(ld_km1 * ld_s);

	// ----------------------------------------------------------------
	// word selection
	// ----------------------------------------------------------------
	wire logic [6:0]  pc_w   = h_first_q ? h_f_q : h_s_q;
	wire logic [63:0] pc_val = (h_q >> (h_cnt_q - pc_w)) & low_mask(pc_w);
	// one fill value for every pad bit
	wire logic [63:0] pc_pad = pc_val | (cfg_fill_q ? ~low_mask(pc_w) : 64'h0);
	wire logic [15:0] pc_word = (h_slot32_q & h_half_q) ? pc_pad[31:16] : pc_pad[15:0];
	wire logic        pc_done = ~(h_slot32_q & ~h_half_q);
	wire logic [15:0] fill_word = {16{cfg_fill_q}};
	wire logic [15:0] iph_word =
		(iph_q == 3'h0) ? ts_q[15:0]  : (iph_q == 3'h1) ? ts_q[31:16] :
		(iph_q == 3'h2) ? ts_q[47:32] : (iph_q == 3'h3) ? ts_q[63:48] :
		(iph_q == 3'h4) ? dh_q[15:0]  : dh_q[31:16];

	wire logic pk_full   = pk_cnt >= 8'h10;
	// nothing is flushed when no bits are left over
	wire logic end_flush = cfg_packed_q & (pk_cnt != 8'h00);
	// odd count of 16-bit words in 32-bit alignment
	wire logic end_need  = end_flush | (cfg_a32_q & par_q);
	wire logic can_emit  = ~stage_v_q | bus.ready;
	wire logic data_rdy  = cfg_packed_q ? pk_full : h_v_q;
	wire logic emit_w    = can_emit & (
		(st_q == ST_CSW_LO) | (st_q == ST_CSW_HI) | (st_q == ST_IPH) |
		((st_q == ST_DATA) & data_rdy) | ((st_q == ST_END) & end_need));
	// channel word low half then high half
	wire logic [15:0] word_w =
		(st_q == ST_CSW_LO) ? csw_q[15:0] :
		(st_q == ST_CSW_HI) ? csw_q[31:16] :
		(st_q == ST_IPH)    ? iph_word :
		(st_q == ST_DATA)   ? (cfg_packed_q ? pk_word : pc_word) :
		end_flush           ? pk_word : fill_word;

	wire logic data_done = last_seen_q & (cfg_packed_q ? ~pk_full : ~h_v_q);
	wire logic frame_end = (st_q == ST_END) & ~end_need;
	wire logic pkt_end   = frame_end & (8'(fcnt_q + 8'h01) == frames_q);
	wire logic iph_start = ((st_q == ST_CSW_HI) & emit_w) | (frame_end & ~pkt_end);
	wire logic pk_pop    = (st_q == ST_DATA) & cfg_packed_q & emit_w;
	wire logic pk_flush  = (st_q == ST_END) & end_flush & emit_w;
	// packed words enter whole, no slot padding
	wire logic pk_push   = accept & cfg_packed_q;
	wire logic item_free = cfg_packed_q ? ~pk_full : ~h_v_q;

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		case (st_q)
			ST_IDLE:   if (ctrl_q[CTRL_EN]) st_d = ST_CSW_LO;
			ST_CSW_LO: if (emit_w) st_d = ST_CSW_HI;
			ST_CSW_HI: if (emit_w) st_d = ST_IPH;
			// headers run in full before the frame data
			ST_IPH:    if (emit_w && iph_q == IPH_LAST) st_d = ST_DATA;
			ST_DATA:   if (data_done) st_d = ST_END;
			ST_END:    if (frame_end) st_d = pkt_end ? ST_FIN : ST_IPH;
			ST_FIN:    if (bus.ready) st_d = ST_IDLE;
			default:   st_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q         <= ST_IDLE;
			cfg_packed_q <= 1'b0;
			cfg_a32_q    <= 1'b0;
			cfg_fill_q   <= 1'b0;
			csw_q        <= 32'h0;
			fcnt_q       <= 8'h00;
			pkt_cnt_q    <= 8'h00;
			par_q        <= 1'b0;
		end else begin
			st_q <= st_d;
			// mode is frozen per packet so a change never tears a frame
			if (pkt_start) begin
				cfg_packed_q <= ctrl_q[CTRL_PACKED];
				cfg_a32_q    <= ctrl_q[CTRL_ALIGN32];
				cfg_fill_q   <= ctrl_q[CTRL_FILL1];
				csw_q        <= csw_w;
			end
			if (pkt_start)
				fcnt_q <= 8'h00;
			else if (frame_end)
				fcnt_q <= 8'(fcnt_q + 8'h01);
			if (pkt_end)
				pkt_cnt_q <= 8'(pkt_cnt_q + 8'h01);
			if (pkt_start)
				par_q <= 1'b0;
			else if (emit_w)
				par_q <= ~par_q;
		end
	end

	// headers sampled once per frame, emitted low word first
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ts_q        <= 64'h0;
			dh_q        <= 32'h0;
			iph_q       <= 3'h0;
			last_seen_q <= 1'b0;
			in_ready_q  <= 1'b0;
		end else begin
			if (iph_start) begin
				ts_q  <= time_stamp;
				dh_q  <= data_header;
				iph_q <= 3'h0;
			end else if (st_q == ST_IPH && emit_w) begin
				iph_q <= 3'(iph_q + 3'h1);
			end
			if (iph_start)
				last_seen_q <= 1'b0;
			else if (accept && in_last)
				last_seen_q <= 1'b1;
			// input opens only after the headers, so data starts on a frame
			in_ready_q <= (st_q == ST_DATA) & ~accept & ~last_seen_q & item_free;
		end
	end

	// ----------------------------------------------------------------
	// unpacked item hold
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			h_v_q      <= 1'b0;
			h_q        <= 64'h0;
			h_cnt_q    <= 7'h00;
			h_f_q      <= 7'h00;
			h_s_q      <= 7'h00;
			h_first_q  <= 1'b0;
			h_slot32_q <= 1'b0;
			h_half_q   <= 1'b0;
		end else if (accept && !cfg_packed_q) begin
			h_v_q      <= 1'b1;
			h_q        <= in_data;
			h_cnt_q    <= in_bits;
			h_f_q      <= ld_f;
			h_s_q      <= ld_s;
			h_first_q  <= 1'b1;
			h_slot32_q <= ld_slot32;
			h_half_q   <= 1'b0;
		end else if (st_q == ST_DATA && !cfg_packed_q && emit_w) begin
			h_half_q <= ~pc_done;
			if (pc_done) begin
				h_cnt_q   <= h_cnt_q - pc_w;
				h_first_q <= 1'b0;
				h_v_q     <= (h_cnt_q != pc_w);
			end
		end
	end

	// ----------------------------------------------------------------
	// staging word: held back one step so the packet's last word is known
	// ----------------------------------------------------------------
	assign bus.valid = stage_v_q & (emit_w | (st_q == ST_FIN));
	assign bus.data  = stage_q;
	assign bus.last  = (st_q == ST_FIN);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage_v_q <= 1'b0;
			stage_q   <= 16'h0000;
		end else if (emit_w) begin
			stage_v_q <= 1'b1;
			stage_q   <= word_w;
		end else if (st_q == ST_FIN && bus.ready) begin
			stage_v_q <= 1'b0;
		end
	end

	bit_packer u_packer (
		.clk       (clk),
		.rst_n     (rst_n),
		.push      (pk_push),
		.push_data (in_data & low_mask(in_bits)),
		.push_bits (in_bits),
		.pop       (pk_pop),
		.flush     (pk_flush),
		.fill      (cfg_fill_q),
		.word      (pk_word),
		.cnt       (pk_cnt)
	);

	word_skid_buffer u_buf (
		.clk       (clk),
		.rst_n     (rst_n),
		.up        (bus.snk),
		.out_valid (out_valid),
		.out_data  (out_data),
		.out_last  (out_last),
		.out_ready (out_ready)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic [3:0] chk_exp_q, chk_cnt_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chk_exp_q <= 4'h0;
			chk_cnt_q <= 4'h0;
		end else if (accept && !cfg_packed_q) begin
			chk_exp_q <= (in_bits <= 7'h10) ? 4'h1 : (cfg_a32_q && in_bits > 7'h20) ?
				4'({(in_bits + 7'h1F) >> 5, 1'b0}) : 4'((in_bits + 7'h0F) >> 4);
			chk_cnt_q <= 4'h0;
		end else if (st_q == ST_DATA && !cfg_packed_q && emit_w) begin
			chk_cnt_q <= 4'(chk_cnt_q + 4'h1);
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence iph_done;
		st_q == ST_IPH && emit_w && iph_q == IPH_LAST;
	endsequence
	sequence item_last_piece;
		st_q == ST_DATA && !cfg_packed_q && emit_w && pc_done && h_cnt_q == pc_w;
	endsequence

	chk_csw_halves: assert property ((st_q == ST_CSW_LO && emit_w) |=>
		(st_q == ST_CSW_HI && stage_q == csw_q[15:0])) else $error("channel word low half misplaced");
	chk_ts_first: assert property ((st_q == ST_IPH && iph_q == 3'h0 && emit_w) |=>
		stage_q == ts_q[15:0]) else $error("time stamp low word not first");
	chk_iph_tail: assert property (iph_done |=>
		(st_q == ST_DATA && stage_q == dh_q[31:16])) else $error("data header not last before data");
	chk_sync_words: assert property (item_last_piece |->
		4'(chk_cnt_q + 4'h1) == chk_exp_q) else $error("sync split into wrong word count");
	chk_first_small: assert property ((accept && !cfg_packed_q && in_bits > 7'h10) |=>
		(h_f_q <= h_s_q && h_f_q != 7'h00)) else $error("first sync piece not smallest");
	chk_pad_upper: assert property ((st_q == ST_DATA && !cfg_packed_q && emit_w && !h_slot32_q
		&& !cfg_fill_q) |=> (stage_q >> $past(pc_w)) == 16'h0000) else $error("pad bits not clear");
	chk_flush_fill: assert property ((pk_flush && !cfg_fill_q) |=>
		(stage_q >> $past(pk_cnt)) == 16'h0000) else $error("packed filler misplaced");
	chk_fill_word: assert property ((st_q == ST_END && !end_flush && emit_w) |=>
		stage_q == {16{cfg_fill_q}}) else $error("filler word not uniform");
	chk_align_even: assert property ((st_q == ST_FIN) |->
		(!cfg_a32_q || !par_q)) else $error("32-bit alignment lost");
	chk_packed_start: assert property (iph_done |->
		pk_cnt == 8'h00) else $error("packed frame starts with leftover bits");
	chk_csw_align: assert property ((st_q == ST_CSW_LO) |->
		csw_q[CSW_ALIGN] == cfg_a32_q) else $error("alignment bit wrong");
	chk_no_fill: assert property ((st_q == ST_END && cfg_packed_q && !cfg_a32_q
		&& pk_cnt == 8'h00) |-> !emit_w) else $error("filler on aligned frame");
endmodule

// ==== pcm_far_end.sv ====
`timescale 1ns/1ps
module pcm_far_end
	import pcm_pack_pkg::*;
(
	input  wire logic              clk,
	output logic                   in_valid,
	input  wire logic              in_ready,
	output logic      [DATA_W-1:0] in_data,
	output logic      [BITS_W-1:0] in_bits,
	output logic                   in_sync,
	output logic                   in_last,
	input  wire logic              out_valid,
	input  wire logic [WORD_W-1:0] out_data,
	input  wire logic              out_last,
	output logic                   out_ready
);
	logic [15:0] rx[$];
	logic        done = 1'b0;
	logic [1:0]  tick = 2'h0;

	initial begin
		in_valid = 1'b0;
		in_data = '0;
		in_bits = 7'h01;
		in_sync = 1'b0;
		in_last = 1'b0;
		out_ready = 1'b0;
	end

	// ---------------------------------------------
	// storage writer: stalls one cycle in four
	// ---------------------------------------------
	always @(posedge clk) begin
		tick <= tick + 2'h1;
		out_ready <= (tick != 2'h0);
		if (out_valid && out_ready) begin
			rx.push_back(out_data);
			if (out_last)
				done <= 1'b1;
		end
	end

	task automatic clear;
		rx.delete();
		done = 1'b0;
	endtask

	// released data lines show the inverse, not the last word
	task automatic send(input logic [DATA_W-1:0] d, input logic [BITS_W-1:0] n, input logic s, input logic l);
		in_valid <= 1'b1;
		in_data <= d;
		in_bits <= n;
		in_sync <= s;
		in_last <= l;
		do @(posedge clk); while (in_ready !== 1'b1);
		in_valid <= 1'b0;
		in_data <= ~d;
		@(posedge clk);
	endtask
endmodule

// ==== pcm_minor_frame_packer_tb.sv ====
`timescale 1ns/1ps
module pcm_minor_frame_packer_tb
	import pcm_pack_pkg::*;
;
	logic              clk = 1'b0;
	logic              rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0]        wb_adr_i;
	logic [31:0]       wb_dat_i, wb_dat_o, csw_e;
	logic [3:0]        wb_sel_i = 4'hF;
	logic [3:0]        lock_status = 4'hF;
	logic [63:0]       time_stamp = 64'h4444_3333_2222_1111;
	logic [31:0]       data_header = 32'h6666_5555;
	logic              in_valid, in_ready, in_sync, in_last, out_valid, out_ready, out_last;
	logic [DATA_W-1:0] in_data;
	logic [BITS_W-1:0] in_bits;
	logic [WORD_W-1:0] out_data;
	logic [15:0]       exp[$];
	int                errors = 0;
	int                checks = 0;

	always #25 clk = ~clk;

	pcm_minor_frame_packer dut (.clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
		.wb_sel_i, .wb_dat_o, .wb_ack_o, .in_valid, .in_ready, .in_data, .in_bits, .in_sync, .in_last,
		.time_stamp, .data_header, .lock_status, .out_valid, .out_data, .out_last, .out_ready);
	pcm_far_end far (.clk, .in_valid, .in_ready, .in_data, .in_bits, .in_sync, .in_last,
		.out_valid, .out_data, .out_last, .out_ready);

	// ---------------------------------------------
	// bus cycles and comparisons
	// ---------------------------------------------
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge clk); while (wb_ack_o !== 1'b1);
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk);
	endtask

	task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chk_words(input string n);
		chk_reg({n, " count"}, 32'(exp.size()), 32'(far.rx.size()));
		foreach (exp[i])
			chk_reg(n, {16'h0, exp[i]}, {16'h0, far.rx[i]});
	endtask

	task automatic intra_packet_headers;
		exp = {exp, time_stamp[15:0], time_stamp[31:16], time_stamp[47:32], time_stamp[63:48],
			data_header[15:0], data_header[31:16]};
	endtask

	// enable then clear at once: only the packet already begun is sent
	task automatic start(input logic [31:0] ctrl, input logic [31:0] csw);
		logic [31:0] r;
		far.clear();
		csw_e = csw;
		exp = {csw[15:0], csw[31:16]};
		wb(1'b1, ADDR_CTRL, ctrl, r);
		wb(1'b1, ADDR_CTRL, 32'h0, r);
	endtask

	task automatic finish(input string n);
		logic [31:0] r;
		repeat (400) if (far.done !== 1'b1) @(posedge clk);
		chk_reg("done", 32'h1, {31'h0, far.done});
		wb(1'b0, ADDR_CSW, 32'h0, r);
		chk_reg("csw", csw_e, r);
		chk_words(n);
	endtask

	// ---------------------------------------------
	// scenarios
	// ---------------------------------------------
	task automatic s_regs;
		logic [31:0] r;
		wb(1'b0, ADDR_CTRL, 32'h0, r);
		chk_reg("ctrl", 32'h0, r);
		wb(1'b0, ADDR_FRAMES, 32'h0, r);
		chk_reg("frames", 32'h1, r);
		wb(1'b1, 8'h10, 32'hF, r);
		wb(1'b0, 8'h10, 32'h0, r);
		chk_reg("unmapped", 32'h0, r);
	endtask

	task automatic s_unpacked16;
		logic [31:0] r;
		wb(1'b1, ADDR_FRAMES, 32'h2, r);
		start(32'h1, 32'h5F04_0000);
		intra_packet_headers();
		exp = {exp, 16'h0ABC, 16'h0123, 16'h0DEF, 16'hBEEF, 16'h005A};
		far.send(64'hABC123, 7'h18, 1'b1, 1'b0);
		far.send(64'hDEF, 7'h0C, 1'b0, 1'b0);
		far.send(64'hBEEF, 7'h10, 1'b0, 1'b0);
		far.send(64'h5A, 7'h08, 1'b0, 1'b1);
		intra_packet_headers();
		exp = {exp, 16'h05A5, 16'h09C3, 16'h06E1, 16'h003C};
		far.send(64'h5_A59C_36E1, 7'h23, 1'b1, 1'b0);
		far.send(64'h3C, 7'h08, 1'b0, 1'b1);
		finish("unpacked16");
	endtask

	task automatic s_packed;
		start(32'hB, 32'h5F08_0000);
		intra_packet_headers();
		exp = {exp, 16'hAABC, 16'hFFF5};
		far.send(64'hABC, 7'h0C, 1'b1, 1'b0);
		far.send(64'h5A, 7'h08, 1'b0, 1'b1);
		intra_packet_headers();
		exp = {exp, 16'h1234, 16'h5678};
		far.send(64'h1234, 7'h10, 1'b1, 1'b0);
		far.send(64'h5678, 7'h10, 1'b0, 1'b1);
		finish("packed16");
	endtask

	task automatic s_unpacked32;
		logic [31:0] r;
		wb(1'b1, ADDR_FRAMES, 32'h1, r);
		start(32'h5, 32'h5F24_0000);
		intra_packet_headers();
		exp = {exp, 16'hA5A5, 16'h0001, 16'hC3C3, 16'h0002, 16'h003C, 16'h0000};
		far.send(64'h6_9696_C3C3, 7'h23, 1'b1, 1'b0);
		far.send(64'h3C, 7'h08, 1'b0, 1'b1);
		finish("unpacked32");
	endtask

	// packed 32-bit alignment, zero fill: partial word then one filler word
	task automatic s_packed32;
		start(32'h7, 32'h5F28_0000);
		intra_packet_headers();
		exp = {exp, 16'h0ABC, 16'h0000};
		far.send(64'hABC, 7'h0C, 1'b1, 1'b1);
		finish("packed32");
	endtask

	task automatic print_verdict;
		if (errors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		#2000000;
		errors++;
		print_verdict();
	end

	initial begin
		{wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
		wb_adr_i = 8'h00;
		wb_dat_i = 32'h0;
		rst_n = 1'b0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		s_regs();
		s_unpacked16();
		s_packed();
		s_unpacked32();
		s_packed32();
		print_verdict();
	end
endmodule
